/* mas_axis_flags.sv */
// module: command and status flag logic of a multi-axis motion controller
//
// Operation
// - servo enable only with all-axes servo-on, axis servo-off clear, no error
// - servo disabled on command clear, axis off, servo error or forced stop
// - servo-on command survives stop state; forced stop, or a dropped command at a tick with no axis positioning, clears it
// - slot modules checked at each cycle tick; fault flag set when any abnormal
// - slot-fault flag transition while operating decelerates all operating axes
// - slot fault blocks starts; cleared only by reset after fault removed
// - jog simultaneous start rising edge starts jog on selected axes
// - jog simultaneous start falling edge decelerates axes it started
// - accept flag shows servo-on accepted, not per-axis servo ready
// - three pulser enables gate pulser pulses; all reset clear
// - overrun flag set when computation time exceeds cycle setting
// - overrun flag sticky; cleared by reset or user reset only
// - per-axis speed change accepting flag while a speed change runs
// - per-axis groups hold 32 axes; variants support 16 or 8
// - auto-decel flag set during automatic deceleration incl final point
// - follow-up target change during deceleration clears auto-decel flag
// - auto-decel flag cleared when all start-complete conditions reached
// - auto-decel flag may set during accel with advanced S-curve
// - auto-decel flag kept on jog release, pulser, stop causes, zero travel
// - zero-speed accepting set on zero/negative change; cleared by change/stop
`timescale 1ns/10ps
module mas_axis_flags
    import mas_pkg::*;
(
    input  wire logic                  ref_clk_in,
    input  wire logic                  arst_n_in,
    input  wire logic                  cycle_tick_in,
    input  wire logic [1:0]            axis_variant_in,
    input  wire logic                  all_axes_servo_on_cmd_in,
    input  wire logic [AXIS_MAX-1:0]   axis_servo_off_cmd_in,
    input  wire logic [AXIS_MAX-1:0]   axis_servo_error_in,
    input  wire logic                  forced_stop_in,
    input  wire logic [AXIS_MAX-1:0]   axis_positioning_in,
    input  wire logic                  slot_module_abnormal_in,
    input  wire logic                  start_request_in,
    input  wire logic                  jog_simultaneous_start_cmd_in,
    input  wire logic [SEL_WORD_W-1:0] jog_sim_axis_select_first_in,
    input  wire logic [SEL_WORD_W-1:0] jog_sim_axis_select_2_in,
    input  wire logic [SEL_WORD_W-1:0] jog_sim_axis_select_3_in,
    input  wire logic [SEL_WORD_W-1:0] jog_sim_axis_select_last_in,
    input  wire logic [PULSER_CNT-1:0] hand_pulser_enable_in,
    input  wire logic [PULSER_CNT-1:0] pulser_pulse_in,
    input  wire logic [CYC_W-1:0]      operation_cycle_setting_in,
    input  wire logic                  compute_busy_in,
    input  wire logic                  overrun_user_reset_in,
    input  wire logic [AXIS_MAX-1:0]   speed_change_run_in,
    input  wire logic [AXIS_MAX-1:0]   auto_decel_active_in,
    input  wire logic [AXIS_MAX-1:0]   follow_target_change_in,
    input  wire logic [AXIS_MAX-1:0]   start_complete_in,
    input  wire logic [AXIS_MAX-1:0]   decel_keep_cause_in,
    input  wire logic [AXIS_MAX-1:0]   zero_speed_accept_in,
    input  wire logic [AXIS_MAX-1:0]   speed_change_accept_in,
    input  wire logic [AXIS_MAX-1:0]   stop_cause_done_in,
    output logic      [AXIS_MAX-1:0]   servo_enable_out,
    output logic                       servo_on_accept_flag_out,
    output logic                       slot_fault_flag_out,
    output logic                       start_permit_out,
    output logic      [AXIS_MAX-1:0]   axis_decel_stop_out,
    output logic      [AXIS_MAX-1:0]   jog_start_out,
    output logic      [PULSER_CNT-1:0] pulser_pulse_out,
    output logic                       operation_cycle_overrun_flag_out,
    output logic      [AXIS_MAX-1:0]   speed_change_accepting_out,
    output logic      [AXIS_MAX-1:0]   auto_decel_flag_out,
    output logic      [AXIS_MAX-1:0]   zero_speed_accepting_out
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // mask of axes that the fitted variant supports
    function automatic logic [AXIS_MAX-1:0] axis_mask(input logic [1:0] v);
        logic [AXIS_MAX-1:0] m;
        m = AXIS_ZERO;
        unique case (v)
            VAR_AXES_16: m[AXIS_MID-1:0] = '1;
            VAR_AXES_8:  m[AXIS_MIN-1:0] = '1;
            default:     m = ~AXIS_ZERO;
        endcase
        return m;
    endfunction

    typedef struct packed {
        logic                  servo_cmd;
        logic                  accept;
        logic                  slot_fault;
        logic                  slot_prev;
        logic                  jog_prev;
        logic [AXIS_MAX-1:0]   jog_set;
        logic [AXIS_MAX-1:0]   jog_start;
        logic [AXIS_MAX-1:0]   decel;
        logic [AXIS_MAX-1:0]   servo_en;
        logic [PULSER_CNT-1:0] pulser_en;
        logic [PULSER_CNT-1:0] pulse;
        logic [CYC_W-1:0]      busy_cnt;
        logic                  overrun;
        logic [AXIS_MAX-1:0]   spd_acc;
        logic [AXIS_MAX-1:0]   adec;
        logic [AXIS_MAX-1:0]   zspd;
        mas_jog_e              jog_st;
    } mas_state_s;

    mas_state_s st_r;
    mas_state_s st_nxt;

    logic [AXIS_MAX-1:0] sel_w;
    logic [AXIS_MAX-1:0] mask_w;
    logic                any_positioning_w;

    assign sel_w = {jog_sim_axis_select_last_in, jog_sim_axis_select_3_in,
                    jog_sim_axis_select_2_in, jog_sim_axis_select_first_in};
    assign mask_w = axis_mask(axis_variant_in);
    assign any_positioning_w = |(axis_positioning_in & mask_w);

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        st_nxt = st_r;
        st_nxt.jog_start = AXIS_ZERO;
        st_nxt.pulse = PULSER_RST;
        // computation time is counted every clock; checked against the
        // cycle length so an overrun is caught even before the tick
        if (cycle_tick_in) begin
            st_nxt.busy_cnt = compute_busy_in ? CYC_CNT_ONE : CYC_CNT_RST;
        end else if (compute_busy_in && st_r.busy_cnt != '1) begin
            st_nxt.busy_cnt = st_r.busy_cnt + CYC_CNT_ONE;
        end
        if (st_r.busy_cnt > operation_cycle_setting_in) begin
            st_nxt.overrun = 1'b1;
        end else if (overrun_user_reset_in) begin
            st_nxt.overrun = 1'b0;
        end
        // forced stop overrides the cycle pacing
        if (forced_stop_in) begin
            st_nxt.servo_cmd = 1'b0;
            st_nxt.accept = 1'b0;
            st_nxt.servo_en = AXIS_ZERO;
        end
        if (cycle_tick_in) begin
            // command taken only while nothing positions
            if (!forced_stop_in && !any_positioning_w) begin
                st_nxt.servo_cmd = all_axes_servo_on_cmd_in;
                st_nxt.accept = all_axes_servo_on_cmd_in;
            end
            for (int i = 0; i < AXIS_MAX; i++) begin
                st_nxt.servo_en[i] = mask_w[i] && st_nxt.servo_cmd
                    && !axis_servo_off_cmd_in[i] && !axis_servo_error_in[i]
                    && !forced_stop_in;
            end
            // sticky until reset
            if (slot_module_abnormal_in) begin
                st_nxt.slot_fault = 1'b1;
            end
            st_nxt.slot_prev = st_r.slot_fault;
            st_nxt.jog_prev = jog_simultaneous_start_cmd_in;
            st_nxt.decel = AXIS_ZERO;
            // the flag only falls at reset, so only its rise stops the axes
            if (st_r.slot_prev != st_r.slot_fault) begin
                st_nxt.decel = axis_positioning_in & mask_w;
            end
            unique case (st_r.jog_st)
                MAS_JOG_IDLE: begin
                    if (jog_simultaneous_start_cmd_in && !st_r.jog_prev
                        && !st_r.slot_fault) begin
                        st_nxt.jog_set = sel_w & mask_w;
                        st_nxt.jog_start = sel_w & mask_w;
                        st_nxt.jog_st = MAS_JOG_RUN;
                    end
                end
                MAS_JOG_RUN: begin
                    if (!jog_simultaneous_start_cmd_in) begin
                        st_nxt.decel = st_nxt.decel | st_r.jog_set;
                        st_nxt.jog_st = MAS_JOG_STOP;
                    end
                end
                MAS_JOG_STOP: begin
                    st_nxt.jog_set = AXIS_ZERO;
                    st_nxt.jog_st = MAS_JOG_IDLE;
                end
            endcase
            st_nxt.pulser_en = hand_pulser_enable_in;
            st_nxt.spd_acc = speed_change_run_in & mask_w;
            for (int i = 0; i < AXIS_MAX; i++) begin
                if (!mask_w[i]) begin
                    st_nxt.adec[i] = 1'b0;
                end else if (auto_decel_active_in[i]) begin
                    st_nxt.adec[i] = 1'b1;
                end else if (decel_keep_cause_in[i]) begin
                    st_nxt.adec[i] = st_r.adec[i];
                end else if (follow_target_change_in[i]
                             || start_complete_in[i]) begin
                    st_nxt.adec[i] = 1'b0;
                end
                // a fresh zero request wins over a clear in the same cycle
                if (!mask_w[i]) begin
                    st_nxt.zspd[i] = 1'b0;
                end else if (zero_speed_accept_in[i]) begin
                    st_nxt.zspd[i] = 1'b1;
                end else if (speed_change_accept_in[i]
                             || stop_cause_done_in[i]) begin
                    st_nxt.zspd[i] = 1'b0;
                end
            end
        end
        // pulses pass at clock rate; enables sampled per cycle
        st_nxt.pulse = pulser_pulse_in & st_r.pulser_en;
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_r <= '{servo_cmd: 1'b0, accept: 1'b0, slot_fault: 1'b0,
                      slot_prev: 1'b0, jog_prev: 1'b0, jog_set: AXIS_ZERO,
                      jog_start: AXIS_ZERO, decel: AXIS_ZERO,
                      servo_en: AXIS_ZERO, pulser_en: PULSER_RST,
                      pulse: PULSER_RST, busy_cnt: CYC_CNT_RST,
                      overrun: 1'b0, spd_acc: AXIS_ZERO,
                      adec: AXIS_ZERO, zspd: AXIS_ZERO,
                      jog_st: MAS_JOG_IDLE};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign servo_enable_out                 = st_r.servo_en;
    assign servo_on_accept_flag_out         = st_r.accept;
    assign slot_fault_flag_out              = st_r.slot_fault;
    assign start_permit_out                 = !st_r.slot_fault
                                              && start_request_in;
    assign axis_decel_stop_out              = st_r.decel;
    assign jog_start_out                    = st_r.jog_start;
    assign pulser_pulse_out                 = st_r.pulse;
    assign operation_cycle_overrun_flag_out = st_r.overrun;
    assign speed_change_accepting_out       = st_r.spd_acc;
    assign auto_decel_flag_out              = st_r.adec;
    assign zero_speed_accepting_out         = st_r.zspd;

    ////////////////////////////////////////////////////////////////////////
    // checks

    sequence seq_fstop;
        forced_stop_in;
    endsequence
    sequence seq_cmd_gone;
        !servo_on_accept_flag_out && servo_enable_out == AXIS_ZERO;
    endsequence

    chk_forced_stop_off: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        seq_fstop |=> seq_cmd_gone)
        else $error("forced stop did not drop servo");
    chk_servo_en_cause: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (servo_enable_out != $past(servo_enable_out) && !$past(forced_stop_in))
        |-> $past(cycle_tick_in))
        else $error("servo enable moved off a cycle tick");
    chk_slot_sticky: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        slot_fault_flag_out |=> slot_fault_flag_out)
        else $error("slot fault flag cleared without reset");
    chk_slot_no_start: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        slot_fault_flag_out |-> !start_permit_out)
        else $error("start permitted under slot fault");
    chk_overrun_sticky: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (operation_cycle_overrun_flag_out && !overrun_user_reset_in)
        |=> operation_cycle_overrun_flag_out)
        else $error("overrun flag dropped on its own");
    chk_overrun_set: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (st_r.busy_cnt > operation_cycle_setting_in)
        |=> operation_cycle_overrun_flag_out)
        else $error("overrun not flagged");
    // masked per-axis conditions that the next tick acts upon
    logic [AXIS_MAX-1:0] zs_req_w;
    logic [AXIS_MAX-1:0] zs_clr_w;
    logic [AXIS_MAX-1:0] ad_req_w;
    logic [AXIS_MAX-1:0] ad_keep_w;
    logic [AXIS_MAX-1:0] ad_clr_w;

    assign zs_req_w  = zero_speed_accept_in & mask_w;
    assign zs_clr_w  = (speed_change_accept_in | stop_cause_done_in)
                       & ~zero_speed_accept_in & mask_w;
    assign ad_req_w  = auto_decel_active_in & mask_w;
    assign ad_keep_w = decel_keep_cause_in & ~auto_decel_active_in
                       & auto_decel_flag_out & mask_w;
    assign ad_clr_w  = (follow_target_change_in | start_complete_in)
                       & ~auto_decel_active_in & ~decel_keep_cause_in
                       & mask_w;

    chk_jog_start_sel: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        jog_start_out != AXIS_ZERO
        |-> $past(cycle_tick_in) && $past(jog_simultaneous_start_cmd_in)
            && !$past(slot_fault_flag_out)
            && (jog_start_out & ~$past(sel_w)) == AXIS_ZERO)
        else $error("jog start off the selected axes");
    chk_jog_decel: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (cycle_tick_in && st_r.jog_st == MAS_JOG_RUN
         && !jog_simultaneous_start_cmd_in)
        |=> (axis_decel_stop_out & $past(st_r.jog_set))
            == $past(st_r.jog_set))
        else $error("jog release did not stop its axes");
    chk_pulser_gate: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        ##1 pulser_pulse_out
            == ($past(pulser_pulse_in) & $past(st_r.pulser_en)))
        else $error("pulser pulse not gated by enable");
    chk_zero_set: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        cycle_tick_in
        |=> (zero_speed_accepting_out & $past(zs_req_w)) == $past(zs_req_w))
        else $error("zero speed accept not flagged");
    chk_zero_clear: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        cycle_tick_in
        |=> (zero_speed_accepting_out & $past(zs_clr_w)) == AXIS_ZERO)
        else $error("zero speed flag not cleared");
    chk_adec_set: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        cycle_tick_in
        |=> (auto_decel_flag_out & $past(ad_req_w)) == $past(ad_req_w))
        else $error("auto decel flag not set");
    chk_adec_keep: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        cycle_tick_in
        |=> (auto_decel_flag_out & $past(ad_keep_w)) == $past(ad_keep_w))
        else $error("auto decel flag dropped by a keep cause");
    chk_adec_clear: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        cycle_tick_in
        |=> (auto_decel_flag_out & $past(ad_clr_w)) == AXIS_ZERO)
        else $error("auto decel flag not cleared");
    chk_accept_take: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (cycle_tick_in && !forced_stop_in && !any_positioning_w)
        |=> servo_on_accept_flag_out == $past(all_axes_servo_on_cmd_in))
        else $error("servo on command not accepted");
    chk_cmd_ignored: assert property (
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (cycle_tick_in && !forced_stop_in && any_positioning_w)
        |=> $stable(servo_on_accept_flag_out))
        else $error("servo on changed during positioning");

endmodule

/* mas_axis_flags_bench.sv */
// testbench: self-checking scenarios for the axis status flag block
`timescale 1ns/10ps
`define CK(n, e, s) begin checks++; if ((s) !== (e)) begin errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module mas_axis_flags_bench;
    int   checks, errors;
    logic ref_clk_in, arst_n_in, cycle_tick_in, all_axes_servo_on_cmd_in;
    logic forced_stop_in, slot_module_abnormal_in, start_request_in;
    logic jog_simultaneous_start_cmd_in, compute_busy_in;
    logic overrun_user_reset_in, servo_on_accept_flag_out;
    logic slot_fault_flag_out, start_permit_out;
    logic operation_cycle_overrun_flag_out;
    logic [1:0]  axis_variant_in;
    logic [7:0]  jog_sim_axis_select_first_in, jog_sim_axis_select_2_in;
    logic [7:0]  jog_sim_axis_select_3_in, jog_sim_axis_select_last_in;
    logic [2:0]  hand_pulser_enable_in, pulser_pulse_in, pulser_pulse_out;
    logic [15:0] operation_cycle_setting_in;
    logic [31:0] axis_servo_off_cmd_in, axis_servo_error_in;
    logic [31:0] axis_positioning_in, speed_change_run_in;
    logic [31:0] auto_decel_active_in, follow_target_change_in;
    logic [31:0] start_complete_in, decel_keep_cause_in;
    logic [31:0] zero_speed_accept_in, speed_change_accept_in;
    logic [31:0] stop_cause_done_in, servo_enable_out, axis_decel_stop_out;
    logic [31:0] jog_start_out, speed_change_accepting_out;
    logic [31:0] auto_decel_flag_out, zero_speed_accepting_out;

    mas_far_side #(.PERIOD(8)) far (.clk_in(ref_clk_in), .arst_n_in,
        .tick_out(cycle_tick_in));
    mas_axis_flags uut (.ref_clk_in, .arst_n_in, .cycle_tick_in,
        .axis_variant_in, .all_axes_servo_on_cmd_in, .axis_servo_off_cmd_in,
        .axis_servo_error_in, .forced_stop_in, .axis_positioning_in,
        .slot_module_abnormal_in, .start_request_in,
        .jog_simultaneous_start_cmd_in, .jog_sim_axis_select_first_in,
        .jog_sim_axis_select_2_in, .jog_sim_axis_select_3_in,
        .jog_sim_axis_select_last_in, .hand_pulser_enable_in,
        .pulser_pulse_in, .operation_cycle_setting_in, .compute_busy_in,
        .overrun_user_reset_in, .speed_change_run_in, .auto_decel_active_in,
        .follow_target_change_in, .start_complete_in, .decel_keep_cause_in,
        .zero_speed_accept_in, .speed_change_accept_in, .stop_cause_done_in,
        .servo_enable_out, .servo_on_accept_flag_out, .slot_fault_flag_out,
        .start_permit_out, .axis_decel_stop_out, .jog_start_out,
        .pulser_pulse_out, .operation_cycle_overrun_flag_out,
        .speed_change_accepting_out, .auto_decel_flag_out,
        .zero_speed_accepting_out);

    initial begin
        ref_clk_in = 1'b0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end

    ////////////////////////////////////////////////////////////////////////
    // wait past the next tick edge; outputs settle one step later
    task automatic tk();
        for (int i = 0; i < 20; i++) begin
            @(posedge ref_clk_in);
            if (cycle_tick_in === 1'b1) break;
        end
        #1;
    endtask

    task automatic t_servo();
        @(posedge ref_clk_in) all_axes_servo_on_cmd_in <= 1'b1;
        tk();
        `CK("enable", 32'hffff_ffff, servo_enable_out)
        `CK("accept", 1'b1, servo_on_accept_flag_out)
        @(posedge ref_clk_in) axis_servo_off_cmd_in <= 32'h0000_0008;
        axis_servo_error_in <= 32'h0000_0020;
        tk();
        `CK("off_err", 32'hffff_ffd7, servo_enable_out)
        `CK("acc_hold", 1'b1, servo_on_accept_flag_out)
        // command dropped mid-move must be ignored
        @(posedge ref_clk_in) axis_positioning_in <= 32'h0000_0001;
        all_axes_servo_on_cmd_in <= 1'b0;
        tk();
        `CK("ignored", 32'hffff_ffd7, servo_enable_out)
        @(posedge ref_clk_in) axis_positioning_in <= 32'h0000_0000;
        tk();
        `CK("dropped", 32'h0000_0000, servo_enable_out)
        `CK("acc_off", 1'b0, servo_on_accept_flag_out)
        @(posedge ref_clk_in) all_axes_servo_on_cmd_in <= 1'b1;
        axis_servo_off_cmd_in <= 32'h0;
        axis_servo_error_in <= 32'h0;
        tk();
        @(posedge ref_clk_in) forced_stop_in <= 1'b1;
        @(posedge ref_clk_in) #1;
        `CK("forced", 32'h0000_0000, servo_enable_out)
        `CK("acc_fst", 1'b0, servo_on_accept_flag_out)
        @(posedge ref_clk_in) forced_stop_in <= 1'b0;
        all_axes_servo_on_cmd_in <= 1'b0;
        tk();
        $display("test servo done");
    endtask

    task automatic t_slot();
        @(posedge ref_clk_in) slot_module_abnormal_in <= 1'b1;
        start_request_in <= 1'b1;
        axis_positioning_in <= 32'h0000_0001;
        tk();
        `CK("fault", 1'b1, slot_fault_flag_out)
        `CK("permit", 1'b0, start_permit_out)
        // jog asked only once the fault is flagged
        @(posedge ref_clk_in) slot_module_abnormal_in <= 1'b0;
        jog_simultaneous_start_cmd_in <= 1'b1;
        jog_sim_axis_select_first_in <= 8'h01;
        tk();
        `CK("jog_ref", 32'h0000_0000, jog_start_out)
        `CK("sticky", 1'b1, slot_fault_flag_out)
        `CK("slot_dec", 32'h0000_0001, axis_decel_stop_out)
        @(posedge ref_clk_in) arst_n_in <= 1'b0;
        jog_simultaneous_start_cmd_in <= 1'b0;
        axis_positioning_in <= 32'h0000_0000;
        @(posedge ref_clk_in) arst_n_in <= 1'b1;
        #1;
        `CK("cleared", 1'b0, slot_fault_flag_out)
        `CK("permit1", 1'b1, start_permit_out)
        $display("test slot done");
    endtask

    task automatic t_jog();
        @(posedge ref_clk_in) jog_simultaneous_start_cmd_in <= 1'b1;
        jog_sim_axis_select_last_in <= 8'h80;
        tk();
        `CK("jog", 32'h8000_0001, jog_start_out)
        @(posedge ref_clk_in) #1;
        `CK("jog_pls", 32'h0000_0000, jog_start_out)
        @(posedge ref_clk_in) jog_simultaneous_start_cmd_in <= 1'b0;
        tk();
        `CK("decel", 32'h8000_0001, axis_decel_stop_out)
        $display("test jog done");
    endtask

    task automatic t_pulser();
        @(posedge ref_clk_in) hand_pulser_enable_in <= 3'h5;
        tk();
        @(posedge ref_clk_in) pulser_pulse_in <= 3'h7;
        @(posedge ref_clk_in) pulser_pulse_in <= 3'h0;
        #1;
        `CK("pulser", 3'h5, pulser_pulse_out)
        $display("test pulser done");
    endtask

    task automatic t_overrun();
        @(posedge ref_clk_in) operation_cycle_setting_in <= 16'h00ff;
        compute_busy_in <= 1'b1;
        tk();
        tk();
        `CK("no_ovr", 1'b0, operation_cycle_overrun_flag_out)
        @(posedge ref_clk_in) operation_cycle_setting_in <= 16'h0003;
        tk();
        tk();
        `CK("ovr", 1'b1, operation_cycle_overrun_flag_out)
        @(posedge ref_clk_in) compute_busy_in <= 1'b0;
        tk();
        tk();
        `CK("ovr_hold", 1'b1, operation_cycle_overrun_flag_out)
        @(posedge ref_clk_in) overrun_user_reset_in <= 1'b1;
        @(posedge ref_clk_in) overrun_user_reset_in <= 1'b0;
        #1;
        `CK("ovr_clr", 1'b0, operation_cycle_overrun_flag_out)
        $display("test overrun done");
    endtask

    task automatic t_axis();
        @(posedge ref_clk_in) axis_variant_in <= 2'h2;
        speed_change_run_in <= 32'hffff_ffff;
        auto_decel_active_in <= 32'h0000_0001;
        zero_speed_accept_in <= 32'h0000_0004;
        tk();
        `CK("v8", 32'h0000_00ff, speed_change_accepting_out)
        `CK("ad_on", 32'h0000_0001, auto_decel_flag_out)
        `CK("zs_on", 32'h0000_0004, zero_speed_accepting_out)
        @(posedge ref_clk_in) axis_variant_in <= 2'h1;
        auto_decel_active_in <= 32'h0;
        decel_keep_cause_in <= 32'h0000_0001;
        start_complete_in <= 32'h0000_0001;
        zero_speed_accept_in <= 32'h0;
        speed_change_accept_in <= 32'h0000_0004;
        tk();
        `CK("v16", 32'h0000_ffff, speed_change_accepting_out)
        `CK("ad_keep", 32'h0000_0001, auto_decel_flag_out)
        `CK("zs_chg", 32'h0000_0000, zero_speed_accepting_out)
        @(posedge ref_clk_in) decel_keep_cause_in <= 32'h0;
        speed_change_accept_in <= 32'h0;
        zero_speed_accept_in <= 32'h0000_0004;
        tk();
        `CK("ad_done", 32'h0000_0000, auto_decel_flag_out)
        @(posedge ref_clk_in) start_complete_in <= 32'h0;
        auto_decel_active_in <= 32'h0000_0002;
        zero_speed_accept_in <= 32'h0;
        stop_cause_done_in <= 32'h0000_0004;
        tk();
        `CK("zs_stop", 32'h0000_0000, zero_speed_accepting_out)
        `CK("ad_on1", 32'h0000_0002, auto_decel_flag_out)
        @(posedge ref_clk_in) auto_decel_active_in <= 32'h0;
        follow_target_change_in <= 32'h0000_0002;
        tk();
        `CK("ad_follow", 32'h0000_0000, auto_decel_flag_out)
        $display("test axis done");
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // budget is a few hundred clocks; the watchdog leaves wide margin
    initial begin
        #200_000;
        errors++;
        close_out();
    end

    initial begin
        {arst_n_in, all_axes_servo_on_cmd_in, forced_stop_in,
         slot_module_abnormal_in, start_request_in, compute_busy_in,
         jog_simultaneous_start_cmd_in, overrun_user_reset_in,
         axis_variant_in, jog_sim_axis_select_first_in,
         jog_sim_axis_select_2_in, jog_sim_axis_select_3_in,
         jog_sim_axis_select_last_in, hand_pulser_enable_in,
         pulser_pulse_in, operation_cycle_setting_in, axis_servo_off_cmd_in,
         axis_servo_error_in, axis_positioning_in, speed_change_run_in,
         auto_decel_active_in, follow_target_change_in, start_complete_in,
         decel_keep_cause_in, zero_speed_accept_in, speed_change_accept_in,
         stop_cause_done_in} = '0;
        repeat (3) @(posedge ref_clk_in);
        arst_n_in <= 1'b1;
        #1;
        `CK("rst_en", 32'h0000_0000, servo_enable_out)
        `CK("rst_pls", 3'h0, pulser_pulse_out)
        t_servo();
        t_slot();
        t_jog();
        t_pulser();
        t_overrun();
        t_axis();
        close_out();
    end
endmodule

/* mas_far_side.sv */
// far side model: motion cycle tick from the positioning engine
`timescale 1ns/10ps
module mas_far_side #(
    parameter int PERIOD = 8
) (
    input  wire logic clk_in,
    input  wire logic arst_n_in,
    output logic      tick_out
);
    int cnt_r;

    // one-clock tick per operation cycle; spacing kept above one clock
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_r <= 0;
            tick_out <= 1'b0;
        end else begin
            cnt_r <= (cnt_r == PERIOD - 1) ? 0 : cnt_r + 1;
            tick_out <= (cnt_r == PERIOD - 1);
        end
    end
endmodule

/* mas_pkg.sv */
// package: constants and types for the motion axis status flag block
package mas_pkg;
    localparam int unsigned AXIS_MAX      = 32;
    localparam int unsigned AXIS_MID      = 16;
    localparam int unsigned AXIS_MIN      = 8;
    localparam int unsigned PULSER_CNT    = 3;
    localparam int unsigned SEL_WORDS     = 4;
    localparam int unsigned SEL_WORD_W    = 8;
    localparam int unsigned CYC_W         = 16;
    localparam logic [31:0] AXIS_ZERO     = 32'h0000_0000;
    localparam logic [2:0]  PULSER_RST    = 3'h0;
    localparam logic [15:0] CYC_CNT_RST   = 16'h0000;
    localparam logic [15:0] CYC_CNT_ONE   = 16'h0001;
    // variant codes for the axis count
    localparam logic [1:0]  VAR_AXES_32   = 2'h0;
    localparam logic [1:0]  VAR_AXES_16   = 2'h1;
    localparam logic [1:0]  VAR_AXES_8    = 2'h2;

    typedef enum logic [1:0] {
        MAS_JOG_IDLE,
        MAS_JOG_RUN,
        MAS_JOG_STOP
    } mas_jog_e;
endpackage
